// File: common/psm_pkg.sv
package psm_pkg;
	localparam int NUM_PHASES = 3;

	// register indices as printed; the register port works in these units
	localparam logic [11:0] OFS_LINE_FREQ = 12'h062;
	localparam logic [11:0] OFS_A_FLAGS   = 12'h144;
	localparam logic [11:0] OFS_A_ENABLES = 12'h145;
	localparam logic [11:0] OFS_A_WRAP    = 12'h146;
	localparam logic [11:0] OFS_A_PF      = 12'h1C6;
	localparam logic [11:0] OFS_PHASE_A_RMS_VOLTAGE    = 12'h1C8;
	localparam logic [11:0] OFS_B_FLAGS   = 12'h230;
	localparam logic [11:0] OFS_B_ENABLES = 12'h231;
	localparam logic [11:0] OFS_B_WRAP    = 12'h232;
	localparam logic [11:0] OFS_B_PF      = 12'h2B2;
	localparam logic [11:0] OFS_PHASE_B_RMS_VOLTAGE    = 12'h2B4;
	localparam logic [11:0] OFS_C_FLAGS   = 12'h31C;
	localparam logic [11:0] OFS_C_ENABLES = 12'h31D;
	localparam logic [11:0] OFS_C_WRAP    = 12'h31E;
	localparam logic [11:0] OFS_C_PF      = 12'h39E;
	localparam logic [11:0] OFS_PHASE_C_RMS_VOLTAGE    = 12'h3A0;

	// event flag / enable bit positions
	localparam int BIT_HIGH_CURRENT  = 0;
	localparam int BIT_HIGH_VOLTAGE  = 1;
	localparam int BIT_LOW_VOLTAGE   = 2;
	localparam int BIT_MISSING_CROSS = 3;
	localparam int BIT_REVERSAL      = 4;
	localparam int BIT_DIRECTION     = 6;
	// energy wrap bit positions
	localparam int BIT_POS_WRAP      = 0;
	localparam int BIT_NEG_WRAP      = 1;
	localparam int BIT_APP_WRAP      = 4;

	localparam logic [7:0] FLAGS_MASK   = 8'h1F;
	localparam logic [7:0] ENABLES_MASK = 8'h1F;
	localparam logic [7:0] WRAP_MASK    = 8'h13;
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [15:0] RESET_PF    = 16'h0000;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} psm_req_t;

	// one dsp-cycle result for a phase
	typedef struct packed {
		logic        valid;
		logic [31:0] rms_voltage;
		logic [31:0] rms_current;
		logic signed [15:0] power_factor;
		logic        negative_power;
		logic        crossing_seen;
		logic        pos_wrap;
		logic        neg_wrap;
		logic        app_wrap;
	} psm_meas_t;

	typedef struct packed {
		logic [15:0] high_current_limit;
		logic [15:0] high_voltage_limit;
		logic [15:0] low_voltage_limit;
		logic [15:0] crossing_timeout_count;
	} psm_limits_t;
endpackage : psm_pkg

// File: hdl/psm_phase_status_regs.sv
// Behaviour
// - event flags stay set until host clears
// - direction change sets reversal flag bit 4
// - no crossing within timeout sets bit 3
// - rms voltage below low limit sets bit 2
// - rms voltage above high limit sets bit 1
// - rms current above limit sets bit 0
// - enabled reversal sets global reversal event
// - enabled missing crossing sets global crossing event
// - enabled low voltage sets global event
// - enabled high voltage sets global event
// - enabled high current sets global event
// - enable bit 6 shows energy direction
// - apparent accumulator overflow sets wrap bit 4
// - negative wrap bit 1, positive bit 0
// - wrap bits sticky, overflow not an error
// - line frequency 16 bit, lsb 0.001 Hz
// - power factor signed, scaled 2^-14
// - raw rms voltage 32 bit per dsp cycle
// - current compared once per dsp cycle
// - low voltage compared per dsp cycle
// - enabled global event drives interrupt request
// - positive accumulation wrap sets positive wrap
module psm_phase_status_regs
	import psm_pkg::*;
#(
	parameter int TIMEOUT_W = 16
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_ce,
	input  wire psm_pkg::psm_req_t       i_req,
	input  wire psm_pkg::psm_limits_t    i_limits,
	input  wire logic                    i_sample_tick,
	input  wire logic [15:0]             i_line_frequency_value,
	input  wire psm_pkg::psm_meas_t      i_meas_a,
	input  wire psm_pkg::psm_meas_t      i_meas_b,
	input  wire psm_pkg::psm_meas_t      i_meas_c,
	output logic [31:0]                  o_rdata,
	output logic                         o_rvalid,
	output logic [4:0]                   o_global_event_set
);
	import psm_pkg::*;

	// clear-on-write-one; a one in wdata clears that flag
	function automatic logic [7:0] sticky(input logic [7:0] cur,
			input logic [7:0] set, input logic [7:0] clr, input logic [7:0] msk);
		sticky = ((cur & ~clr) | set) & msk;
	endfunction : sticky

	function automatic int phase_of(input logic [11:0] a, input logic [11:0] base_a,
			input logic [11:0] base_b, input logic [11:0] base_c);
		if (a == base_a) phase_of = 0;
		else if (a == base_b) phase_of = 1;
		else if (a == base_c) phase_of = 2;
		else phase_of = -1;
	endfunction : phase_of

	psm_meas_t meas [NUM_PHASES];
	assign meas[0] = i_meas_a;
	assign meas[1] = i_meas_b;
	assign meas[2] = i_meas_c;

	logic [7:0]     flags [NUM_PHASES];
	logic [7:0]     next_flags [NUM_PHASES];
	logic [7:0]     enables [NUM_PHASES];
	logic [7:0]     next_enables [NUM_PHASES];
	logic [7:0]     wrap [NUM_PHASES];
	logic [7:0]     next_wrap [NUM_PHASES];
	logic           direction [NUM_PHASES];
	logic           next_direction [NUM_PHASES];
	logic           dir_known [NUM_PHASES];
	logic           next_dir_known [NUM_PHASES];
	logic [15:0]    pf [NUM_PHASES];
	logic [15:0]    next_pf [NUM_PHASES];
	logic [31:0]    vrms [NUM_PHASES];
	logic [31:0]    next_vrms [NUM_PHASES];
	logic [TIMEOUT_W-1:0] zx_count [NUM_PHASES];
	logic [TIMEOUT_W-1:0] next_zx_count [NUM_PHASES];
	logic [7:0]     evt [NUM_PHASES];
	logic [15:0]    line_freq;
	logic [15:0]    next_line_freq;
	logic [31:0]    next_rdata;
	logic           next_rvalid;
	logic [4:0]     next_global;

	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++) begin : g_phase
			logic [TIMEOUT_W-1:0] limit_cnt;
			assign limit_cnt = TIMEOUT_W'(i_limits.crossing_timeout_count);

			always_comb begin
				evt[g] = 8'h00;
				next_zx_count[g] = zx_count[g];
				next_direction[g] = direction[g];
				next_dir_known[g] = dir_known[g];
				next_pf[g] = pf[g];
				next_vrms[g] = vrms[g];
				// zero-crossing watchdog counts adc sample periods
				if (meas[g].valid && meas[g].crossing_seen) begin
					next_zx_count[g] = '0;
				end else if (i_sample_tick) begin
					// the tick that completes the timeout window raises the flag
					if (limit_cnt != '0 && zx_count[g] >= limit_cnt - 1'b1) begin
						evt[g][BIT_MISSING_CROSS] = 1'b1;
						next_zx_count[g] = '0;
					end else begin
						next_zx_count[g] = zx_count[g] + 1'b1;
					end
				end
				// threshold checks happen only on a dsp-cycle result
				if (meas[g].valid) begin
					next_vrms[g] = meas[g].rms_voltage;
					next_pf[g] = meas[g].power_factor;
					// compare against bits 23:8, full scale 0x10000
					if (meas[g].rms_current[23:8] > i_limits.high_current_limit) begin
						evt[g][BIT_HIGH_CURRENT] = 1'b1;
					end
					if (meas[g].rms_voltage[23:8] > i_limits.high_voltage_limit) begin
						evt[g][BIT_HIGH_VOLTAGE] = 1'b1;
					end
					if (meas[g].rms_voltage[23:8] < i_limits.low_voltage_limit) begin
						evt[g][BIT_LOW_VOLTAGE] = 1'b1;
					end
					// first result only learns direction, no false reversal
					if (dir_known[g] && meas[g].negative_power != direction[g]) begin
						evt[g][BIT_REVERSAL] = 1'b1;
					end
					next_direction[g] = meas[g].negative_power;
					next_dir_known[g] = 1'b1;
				end
			end
		end
	endgenerate

	always_comb begin
		int p;
		logic [7:0] clr;
		logic [7:0] wset;
		p = 0;
		clr = 8'h00;
		wset = 8'h00;
		next_global = 5'h00;
		next_line_freq = i_line_frequency_value;
		for (int k = 0; k < NUM_PHASES; k++) begin
			next_flags[k] = sticky(flags[k], evt[k], 8'h00, FLAGS_MASK);
			next_enables[k] = enables[k];
			wset = 8'h00;
			if (meas[k].valid) begin
				wset[BIT_POS_WRAP] = meas[k].pos_wrap;
				wset[BIT_NEG_WRAP] = meas[k].neg_wrap;
				wset[BIT_APP_WRAP] = meas[k].app_wrap;
			end
			// wrap is informational only; host adds 2^32
			next_wrap[k] = sticky(wrap[k], wset, 8'h00, WRAP_MASK);
			// enabled events feed the global flag register as pulses
			next_global = next_global | (evt[k][4:0] & enables[k][4:0]);
		end
		if (i_req.wr) begin
			clr = i_req.wdata[7:0];
			p = phase_of(i_req.addr, OFS_A_FLAGS, OFS_B_FLAGS, OFS_C_FLAGS);
			if (p >= 0) next_flags[p] = sticky(flags[p], evt[p], clr, FLAGS_MASK);
			p = phase_of(i_req.addr, OFS_A_WRAP, OFS_B_WRAP, OFS_C_WRAP);
			if (p >= 0) next_wrap[p] = ((wrap[p] & ~clr) | (next_wrap[p] & ~wrap[p]))
				& WRAP_MASK;
			p = phase_of(i_req.addr, OFS_A_ENABLES, OFS_B_ENABLES, OFS_C_ENABLES);
			if (p >= 0) next_enables[p] = clr & ENABLES_MASK;
		end
		next_rvalid = i_req.rd;
		next_rdata = 32'h0000_0000;
		if (i_req.rd) begin
			case (i_req.addr)
				OFS_LINE_FREQ: next_rdata = {16'h0000, line_freq};
				OFS_A_FLAGS:   next_rdata = {24'h000000, flags[0]};
				OFS_B_FLAGS:   next_rdata = {24'h000000, flags[1]};
				OFS_C_FLAGS:   next_rdata = {24'h000000, flags[2]};
				OFS_A_ENABLES: next_rdata = {24'h000000, enables[0] | {1'b0, direction[0], 6'h00}};
				OFS_B_ENABLES: next_rdata = {24'h000000, enables[1] | {1'b0, direction[1], 6'h00}};
				OFS_C_ENABLES: next_rdata = {24'h000000, enables[2] | {1'b0, direction[2], 6'h00}};
				OFS_A_WRAP:    next_rdata = {24'h000000, wrap[0]};
				OFS_B_WRAP:    next_rdata = {24'h000000, wrap[1]};
				OFS_C_WRAP:    next_rdata = {24'h000000, wrap[2]};
				OFS_A_PF:      next_rdata = {16'h0000, pf[0]};
				OFS_B_PF:      next_rdata = {16'h0000, pf[1]};
				OFS_C_PF:      next_rdata = {16'h0000, pf[2]};
				OFS_PHASE_A_RMS_VOLTAGE:    next_rdata = vrms[0];
				OFS_PHASE_B_RMS_VOLTAGE:    next_rdata = vrms[1];
				OFS_PHASE_C_RMS_VOLTAGE:    next_rdata = vrms[2];
				default:       next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < NUM_PHASES; k++) begin
				flags[k] <= RESET_BYTE;
				enables[k] <= RESET_BYTE;
				wrap[k] <= RESET_BYTE;
				direction[k] <= 1'b0;
				dir_known[k] <= 1'b0;
				pf[k] <= RESET_PF;
				vrms[k] <= '0;
				zx_count[k] <= '0;
			end
			line_freq <= '0;
			o_rdata <= '0;
			o_rvalid <= 1'b0;
			o_global_event_set <= '0;
		end else if (i_ce) begin
			for (int k = 0; k < NUM_PHASES; k++) begin
				flags[k] <= next_flags[k];
				enables[k] <= next_enables[k];
				wrap[k] <= next_wrap[k];
				direction[k] <= next_direction[k];
				dir_known[k] <= next_dir_known[k];
				pf[k] <= next_pf[k];
				vrms[k] <= next_vrms[k];
				zx_count[k] <= next_zx_count[k];
			end
			line_freq <= next_line_freq;
			o_rdata <= next_rdata;
			o_rvalid <= next_rvalid;
			o_global_event_set <= next_global;
		end
	end
endmodule : psm_phase_status_regs

// File: test/psm_phase_status_regs_props.sv
module psm_props
	import psm_pkg::*;
(
	input wire logic                 i_core_clk,
	input wire logic                 i_rst,
	input wire logic                 i_ce,
	input wire psm_pkg::psm_req_t    i_req,
	input wire psm_pkg::psm_limits_t i_limits,
	input wire logic [15:0]          i_line_frequency_value,
	input wire psm_pkg::psm_meas_t   i_meas_a,
	input wire psm_pkg::psm_meas_t   i_meas_b,
	input wire psm_pkg::psm_meas_t   i_meas_c,
	input wire logic [31:0]          o_rdata,
	input wire logic                 o_rvalid,
	input wire logic [4:0]           o_global_event_set
);
	// limits passed in so the assign sees their changes
	function automatic logic [2:0] lim(input psm_meas_t m, input psm_limits_t l);
		lim = {m.rms_voltage[23:8] < l.low_voltage_limit,
			m.rms_voltage[23:8] > l.high_voltage_limit,
			m.rms_current[23:8] > l.high_current_limit} & {3{m.valid}};
	endfunction : lim
	wire logic [2:0] cause = (lim(i_meas_a, i_limits) | lim(i_meas_b, i_limits)
		| lim(i_meas_c, i_limits)) & {3{i_ce}};
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence s_rd(logic [11:0] a);
		i_ce && i_req.rd && i_req.addr == a;
	endsequence
	AST_UNMAPPED: assert property (s_rd(12'h147) |=> o_rvalid && o_rdata == 32'h0)
		else $error("unmapped read");
	AST_RD_PULSE: assert property (o_rvalid && $past(i_ce) |-> $past(i_req.rd))
		else $error("stray read answer");
	AST_RESV_FLAGS: assert property (s_rd(OFS_A_FLAGS) |=> o_rdata[31:5] == '0)
		else $error("flags reserved bits set");
	AST_RESV_ENABLES: assert property (s_rd(OFS_A_ENABLES) |=>
		o_rdata[31:7] == '0 && !o_rdata[5]) else $error("enables reserved bits set");
	AST_RESV_WRAP: assert property (s_rd(OFS_B_WRAP) |=>
		(o_rdata & ~32'h13) == 32'h0) else $error("wrap reserved bits set");
	AST_LINE_FREQ: assert property (s_rd(OFS_LINE_FREQ) ##0 ($past(i_ce) && !$past(i_rst)
		&& $stable(i_line_frequency_value)) |=> o_rdata == {16'h0000, $past(i_line_frequency_value)})
		else $error("line frequency mismatch");
	AST_EVENT_CAUSE: assert property ($past(i_ce) |->
		(o_global_event_set[2:0] & ~$past(cause)) == 3'h0) else $error("event without cause");
	AST_REVERSAL_CAUSE: assert property ($past(i_ce) && o_global_event_set[4] |->
		$past(i_meas_a.valid || i_meas_b.valid || i_meas_c.valid)) else $error("reversal w/o result");
endmodule : psm_props

// File: test/psm_host.sv
module psm_host
	import psm_pkg::*;
(
	input  wire logic         i_core_clk,
	input  wire logic [31:0]  i_rdata,
	input  wire logic         i_rvalid,
	output psm_pkg::psm_req_t o_req
);
	initial o_req = '0;
	// released index is inverted so a stale address never looks current
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge i_core_clk);
		o_req <= '{w, !w, a, {24'h000000, d}};
		@(posedge i_core_clk);
		o_req <= '{1'b0, 1'b0, ~a, 32'h00000000};
		@(posedge i_core_clk);
		q = i_rvalid ? i_rdata : 'x;
	endtask : xfer
	function automatic logic [32:0] used(input logic [31:0] prev, cur, input logic wrap);
		used = {1'b0, cur} - {1'b0, prev} + (wrap ? 33'h100000000 : 33'h0);
	endfunction : used
endmodule : psm_host

// File: test/psm_phase_status_regs_test.sv
module psm_phase_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import psm_pkg::*;
	typedef struct packed {
		logic [1:0] p; logic [15:0] v; logic [15:0] i; logic [3:0] fl;
		logic [4:0] ev; logic [7:0] fx; logic [7:0] wx;
	} psm_row_t;
	localparam logic [11:0] BASE [3] = '{OFS_A_FLAGS, OFS_B_FLAGS, OFS_C_FLAGS};
	localparam logic [7:0] EN [3] = '{8'h1F, 8'h00, 8'h1F};
	// fl: negative, apparent wrap, negative wrap, positive wrap
	psm_row_t rows [7] = '{
		'{2'h0, 16'h8000, 16'h9000, 4'h0, 5'h01, 8'h01, 8'h00},
		'{2'h0, 16'hC001, 16'h1000, 4'h8, 5'h12, 8'h12, 8'h00},
		'{2'h0, 16'h3FFF, 16'h1000, 4'hE, 5'h04, 8'h04, 8'h12},
		'{2'h0, 16'h4000, 16'h8000, 4'h1, 5'h10, 8'h10, 8'h01},
		'{2'h1, 16'hC001, 16'h9000, 4'h0, 5'h00, 8'h03, 8'h00},
		'{2'h2, 16'h3FFF, 16'h1000, 4'h8, 5'h04, 8'h04, 8'h00},
		'{2'h2, 16'hC000, 16'h1000, 4'h0, 5'h10, 8'h10, 8'h00}};
	logic i_core_clk, i_rst, i_ce, i_sample_tick, o_rvalid;
	logic [15:0] i_line_frequency_value;
	psm_req_t i_req;
	psm_limits_t i_limits;
	psm_meas_t m [3];
	logic [31:0] o_rdata, q;
	logic [4:0] o_global_event_set, ev;
	int n_fail, n_compared;
	psm_phase_status_regs u_psm_phase_status_regs (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_ce(i_ce), .i_req(i_req), .i_limits(i_limits), .i_sample_tick(i_sample_tick),
		.i_line_frequency_value(i_line_frequency_value), .i_meas_a(m[0]), .i_meas_b(m[1]),
		.i_meas_c(m[2]), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.o_global_event_set(o_global_event_set));
	psm_host u_psm_host (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
		.o_req(i_req));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		u_psm_host.xfer(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rc
	task automatic wr(input logic [11:0] a, input logic [7:0] b);
		logic [31:0] t;
		u_psm_host.xfer(1'b1, a, b, t);
	endtask : wr
	task automatic dsp(input psm_row_t r);
		@(posedge i_core_clk);
		m[r.p] <= '{1'b1, {8'h00, r.v, 8'h00}, {8'h00, r.i, 8'h00}, 16'h1234, r.fl[3], 1'b1,
			r.fl[0], r.fl[1], r.fl[2]};
		@(posedge i_core_clk);
		m[r.p].valid <= 1'b0;
		@(posedge i_core_clk);
		ev = o_global_event_set;
	endtask : dsp
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			i_sample_tick <= 1'b1;
			@(posedge i_core_clk);
			i_sample_tick <= 1'b0;
		end
	endtask : tick
	task automatic test_done();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	initial begin
		#1000000;
		n_fail++;
		test_done();
	end
	initial begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_sample_tick = 1'b0;
		i_line_frequency_value = 16'hC350;
		i_limits = '{16'h8000, 16'hC000, 16'h4000, 16'h0000};
		m = '{default: '0};
		repeat (10) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 3; k++) begin
				rc(BASE[p] + 12'(k), 32'h0);
			end
			wr(BASE[p] + 12'h1, EN[p]);
		end
		foreach (rows[n]) begin
			dsp(rows[n]);
			chk(32'(ev), 32'(rows[n].ev));
			rc(BASE[rows[n].p], 32'(rows[n].fx));
			wr(BASE[rows[n].p], 8'hFF);
			rc(BASE[rows[n].p], 32'h0);
			rc(BASE[rows[n].p] + 12'h2, 32'(rows[n].wx));
			wr(BASE[rows[n].p] + 12'h2, 8'hFF);
			rc(BASE[rows[n].p] + 12'h1, 32'({1'b0, rows[n].fl[3], 6'h00} | EN[rows[n].p]));
		end
		$display("table done");
		// clear and a fresh event on one edge: the event must survive
		fork
			wr(OFS_A_FLAGS, 8'h01);
			dsp(rows[0]);
		join
		rc(OFS_A_FLAGS, 32'h01);
		wr(OFS_A_ENABLES, 8'hFF);
		rc(OFS_A_ENABLES, 32'h1F);
		wr(OFS_A_PF, 8'h00);
		rc(OFS_A_PF, 32'h1234);
		rc(OFS_PHASE_A_RMS_VOLTAGE, 32'h00800000);
		rc(12'h147, 32'h0);
		rc(OFS_LINE_FREQ, 32'hC350);
		$display("access done");
		i_limits.crossing_timeout_count <= 16'h0003;
		tick(2);
		rc(OFS_B_FLAGS, 32'h0);
		tick(1);
		@(posedge i_core_clk);
		chk(32'(o_global_event_set), 32'h08);
		rc(OFS_B_FLAGS, 32'h08);
		$display("crossing done");
		test_done();
	end
endmodule : psm_phase_status_regs_test
bind psm_phase_status_regs psm_props u_psm_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_ce(i_ce), .i_req(i_req), .i_limits(i_limits),
	.i_line_frequency_value(i_line_frequency_value), .i_meas_a(i_meas_a),
	.i_meas_b(i_meas_b), .i_meas_c(i_meas_c), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
	.o_global_event_set(o_global_event_set));
